// ### include/remote_map_pkg.sv
// Purpose: Shared constants for the remote target map and link status bank.
// Assumes: Registers are 8 bits wide, at their printed byte offsets.
// Notes: Both serial ports share one register map, chosen by the port select.
package remote_map_pkg;

    localparam int unsigned NUM_PORTS = 2;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned I2C_ADDR_W = 7;
    localparam int unsigned COUNT_W = 16;

    localparam logic [7:0] OFS_TARGET_ADDR = 8'h07;
    localparam logic [7:0] OFS_TARGET_ALIAS = 8'h08;
    localparam logic [7:0] OFS_CRC_COUNT_LO = 8'h0A;
    localparam logic [7:0] OFS_CRC_COUNT_HI = 8'h0B;
    localparam logic [7:0] OFS_LINK_STATUS = 8'h0C;

    // Address fields sit in bits 7:1; bit 0 is reserved and reads zero.
    localparam int unsigned ADDR_FIELD_LSB = 1;

    localparam int unsigned STAT_LINK_DETECT = 0;
    localparam int unsigned STAT_CRC_ERROR = 1;
    localparam int unsigned STAT_CLOCK_VALID = 2;
    localparam int unsigned STAT_SELFTEST_CRC = 3;
    localparam int unsigned STAT_LINK_LOST = 4;

    localparam logic [6:0] RST_TARGET_FIELD = 7'h00;
    localparam logic [6:0] RST_ALIAS_FIELD = 7'h00;
    localparam logic [15:0] RST_CRC_COUNT = 16'h0000;
    localparam logic [15:0] CRC_COUNT_MAX = 16'hFFFF;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [6:0] ADDR_DISABLED = 7'h00;

    // Sticky flag update: a set in the same cycle as a clear wins.
    function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
        sticky_next = set | (cur & ~clr);
    endfunction : sticky_next

endpackage : remote_map_pkg

// ### core/port_status_slot.sv
// Purpose: Mapping, CRC error count and sticky status for one serial port.
// Assumes: All event inputs except link detect, which is a level, are single-cycle pulses on the core clock.
// Notes: The link lost event is taken from a falling edge of link detect.
module port_status_slot
    import remote_map_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Register writes
    input wire logic wr_target_i,
    input wire logic wr_alias_i,
    input wire logic [6:0] wr_field_i,
    input wire logic crc_reset_i,
    // Link events
    input wire logic link_detect_i,
    input wire logic crc_error_i,
    input wire logic selftest_crc_error_i,
    input wire logic selftest_restart_i,
    // State
    output logic [6:0] target_field_o,
    output logic [6:0] alias_field_o,
    output logic [15:0] crc_count_o,
    output logic link_lost_o,
    output logic selftest_crc_o,
    output logic crc_error_o
);

    logic link_detect_q;
    logic link_loss;

    assign link_loss = link_detect_q & ~link_detect_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            link_detect_q <= 1'b0;
        end else begin
            link_detect_q <= link_detect_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            target_field_o <= RST_TARGET_FIELD;
            alias_field_o <= RST_ALIAS_FIELD;
        end else begin
            if (wr_target_i) begin
                target_field_o <= wr_field_i; // [RULE_01]
            end
            if (wr_alias_i) begin
                alias_field_o <= wr_field_i; // [RULE_03]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            crc_count_o <= RST_CRC_COUNT;
        end else if (crc_error_i) begin
            if (crc_reset_i) begin
                crc_count_o <= RST_CRC_COUNT + 16'h0001;
            end else if (crc_count_o != CRC_COUNT_MAX) begin
                crc_count_o <= crc_count_o + 16'h0001; // [RULE_13]
            end
        end else if (crc_reset_i) begin
            crc_count_o <= RST_CRC_COUNT; // [RULE_06]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            link_lost_o <= 1'b0;
            selftest_crc_o <= 1'b0;
            crc_error_o <= 1'b0;
        end else begin
            link_lost_o <= sticky_next(link_lost_o, link_loss, crc_reset_i); // [RULE_08]
            selftest_crc_o <= sticky_next(selftest_crc_o, selftest_crc_error_i,
                link_loss | selftest_restart_i | crc_reset_i); // [RULE_09]
            crc_error_o <= sticky_next(crc_error_o, crc_error_i,
                link_loss | crc_reset_i); // [RULE_11]
        end
    end

endmodule : port_status_slot

// ### core/remote_slave_map_link_status.sv
// Purpose: Per-port remote target map, CRC error counter and link status bank.
// Assumes: Register port and event inputs are synchronous to CORE_CLK_I.
// Notes: Read data appears one cycle after the read strobe.
// Functional notes
// [RULE_01] Hold remote target address in bits 7:1.
// [RULE_02] Replace alias address with stored target address.
// [RULE_03] Hold alias address in bits 7:1.
// [RULE_04] Zero target or alias blocks remote access.
// [RULE_05] Sixteen-bit read-only CRC error counter, two bytes.
// [RULE_06] CRC error reset clears the whole counter.
// [RULE_07] Port select picks which port registers address.
// [RULE_08] Sticky link lost flag, cleared by reset.
// [RULE_09] Self-test CRC flag, cleared by loss/restart/reset.
// [RULE_10] Status bit 2 shows input clock valid.
// [RULE_11] CRC error flag, cleared by loss or reset.
// [RULE_12] Status bit 0 shows live link detect.
// [RULE_13] Counter increments per error and saturates.
module remote_slave_map_link_status
    import remote_map_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    // Register access port
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    // Control bits
    input wire logic SECOND_PORT_SELECT_I,
    input wire logic CRC_ERROR_RESET_I,
    // Per-port link events, index 0 and 1 are the two serial ports
    input wire logic [1:0] LINK_DETECT_I,
    input wire logic [1:0] CRC_ERROR_I,
    input wire logic [1:0] SELFTEST_CRC_ERROR_I,
    input wire logic [1:0] SELFTEST_RESTART_I,
    input wire logic INPUT_CLOCK_VALID_I,
    // Local I2C address request
    input wire logic REQ_VALID_I,
    input wire logic REQ_PORT_I,
    input wire logic [6:0] REQ_ADDR_I,
    // Forwarded request toward the control channel
    output logic FWD_VALID_O,
    output logic FWD_BLOCKED_O,
    output logic FWD_REMAPPED_O,
    output logic [6:0] FWD_ADDR_O
);

    logic [6:0] target_field [NUM_PORTS];
    logic [6:0] alias_field [NUM_PORTS];
    logic [15:0] crc_count [NUM_PORTS];
    logic [NUM_PORTS-1:0] link_lost;
    logic [NUM_PORTS-1:0] selftest_crc;
    logic [NUM_PORTS-1:0] crc_error;
    logic [NUM_PORTS-1:0] wr_target;
    logic [NUM_PORTS-1:0] wr_alias;
    logic sel;
    logic [7:0] status_byte;
    logic [7:0] read_byte;
    logic [6:0] req_target;
    logic [6:0] req_alias;
    logic req_hit;
    logic req_blocked;

    assign sel = SECOND_PORT_SELECT_I; // [RULE_07]

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            wr_target[p] = REG_WR_I && (REG_ADDR_I == OFS_TARGET_ADDR) && (sel == p[0]);
            wr_alias[p] = REG_WR_I && (REG_ADDR_I == OFS_TARGET_ALIAS) && (sel == p[0]);
        end
    end

    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        port_status_slot u_slot (
            .clk_i(CORE_CLK_I),
            .srst_i(SRST_I),
            .wr_target_i(wr_target[g]),
            .wr_alias_i(wr_alias[g]),
            .wr_field_i(REG_WDATA_I[7:ADDR_FIELD_LSB]),
            .crc_reset_i(CRC_ERROR_RESET_I),
            .link_detect_i(LINK_DETECT_I[g]),
            .crc_error_i(CRC_ERROR_I[g]),
            .selftest_crc_error_i(SELFTEST_CRC_ERROR_I[g]),
            .selftest_restart_i(SELFTEST_RESTART_I[g]),
            .target_field_o(target_field[g]),
            .alias_field_o(alias_field[g]),
            .crc_count_o(crc_count[g]),
            .link_lost_o(link_lost[g]),
            .selftest_crc_o(selftest_crc[g]),
            .crc_error_o(crc_error[g])
        );
    end

    always_comb begin
        status_byte = 8'h00;
        status_byte[STAT_LINK_LOST] = link_lost[sel]; // [RULE_08]
        status_byte[STAT_SELFTEST_CRC] = selftest_crc[sel]; // [RULE_09]
        status_byte[STAT_CLOCK_VALID] = INPUT_CLOCK_VALID_I; // [RULE_10]
        status_byte[STAT_CRC_ERROR] = crc_error[sel]; // [RULE_11]
        status_byte[STAT_LINK_DETECT] = LINK_DETECT_I[sel]; // [RULE_12]
    end

    // Unmapped offsets and reserved bits read as zero.
    always_comb begin
        unique case (REG_ADDR_I)
            OFS_TARGET_ADDR: read_byte = {target_field[sel], 1'b0};
            OFS_TARGET_ALIAS: read_byte = {alias_field[sel], 1'b0};
            OFS_CRC_COUNT_LO: read_byte = crc_count[sel][7:0]; // [RULE_05]
            OFS_CRC_COUNT_HI: read_byte = crc_count[sel][15:8]; // [RULE_05]
            OFS_LINK_STATUS: read_byte = status_byte;
            default: read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            REG_RDATA_O <= RST_READ_DATA;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I;
            if (REG_RD_I) begin
                REG_RDATA_O <= read_byte;
            end
        end
    end

    assign req_target = target_field[REQ_PORT_I];
    assign req_alias = alias_field[REQ_PORT_I];
    assign req_hit = (REQ_ADDR_I == req_alias);
    assign req_blocked = req_hit &&
        ((req_target == ADDR_DISABLED) || (req_alias == ADDR_DISABLED)); // [RULE_04]

    // A request that matches no alias passes through with its own address.
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            FWD_VALID_O <= 1'b0;
            FWD_BLOCKED_O <= 1'b0;
            FWD_REMAPPED_O <= 1'b0;
            FWD_ADDR_O <= ADDR_DISABLED;
        end else begin
            FWD_VALID_O <= REQ_VALID_I && !req_blocked;
            FWD_BLOCKED_O <= REQ_VALID_I && req_blocked; // [RULE_04]
            FWD_REMAPPED_O <= REQ_VALID_I && req_hit && !req_blocked;
            if (REQ_VALID_I) begin
                FWD_ADDR_O <= (req_hit && !req_blocked) ? req_target : REQ_ADDR_I; // [RULE_02]
            end
        end
    end

endmodule : remote_slave_map_link_status

// ### tb/remote_map_chk.sv
// Purpose: Port assertions for the remote map and link status bank.
// Assumes: Read data shows the state held at the read edge.
// Notes: Attached to the top module by the bind below.
module remote_map_chk (
    // Observed ports
    input wire logic CORE_CLK_I, SRST_I, REG_RD_I, REG_RVALID_O,
    input wire logic [7:0] REG_ADDR_I, REG_RDATA_O,
    input wire logic SECOND_PORT_SELECT_I, CRC_ERROR_RESET_I, INPUT_CLOCK_VALID_I,
    input wire logic [1:0] LINK_DETECT_I, CRC_ERROR_I,
    input wire logic REQ_VALID_I, FWD_VALID_O, FWD_BLOCKED_O, FWD_REMAPPED_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);
    sequence stat0_s;
        REG_RD_I && REG_ADDR_I == 8'h0C && !SECOND_PORT_SELECT_I;
    endsequence
    sequence loss_s;
        $fell(LINK_DETECT_I[0]) && !$past(SRST_I) ##1 !CRC_ERROR_RESET_I [*3];
    endsequence
    read_valid_a: assert property (REG_RD_I |=> REG_RVALID_O)
        else $error("read without valid");
    fwd_cause_a: assert property (FWD_VALID_O || FWD_BLOCKED_O |-> $past(REQ_VALID_I))
        else $error("forward without request");
    blocked_only_a: assert property (FWD_BLOCKED_O |-> !FWD_REMAPPED_O && !FWD_VALID_O)
        else $error("blocked request remapped");
    live_link_a: assert property (stat0_s |=> REG_RDATA_O[0] == $past(LINK_DETECT_I[0]))
        else $error("link bit wrong");
    clock_bit_a: assert property (REG_RD_I && REG_ADDR_I == 8'h0C |=>
        REG_RDATA_O[2] == $past(INPUT_CLOCK_VALID_I)) else $error("clock bit wrong");
    field_lsb_a: assert property (REG_RD_I && (REG_ADDR_I == 8'h07 || REG_ADDR_I == 8'h08)
        |=> !REG_RDATA_O[0]) else $error("address field bit 0 set");
    count_clear_a: assert property (REG_RD_I && REG_ADDR_I[7:1] == 7'h05
        && $past(CRC_ERROR_RESET_I) && $past(CRC_ERROR_I) == 2'b00 |=> REG_RDATA_O == 8'h00)
        else $error("count not cleared");
    crc_flag_a: assert property (CRC_ERROR_I[0] ##1 stat0_s |=> REG_RDATA_O[1])
        else $error("crc flag not set");
    link_lost_a: assert property (loss_s ##0 stat0_s |=> REG_RDATA_O[4])
        else $error("link lost flag not set");
endmodule : remote_map_chk
bind remote_slave_map_link_status remote_map_chk remote_map_chk_i (.*);

// ### tb/link_far_end.sv
// Purpose: Far-end model raising link, CRC and self-test events.
// Assumes: Events change on the falling clock edge only.
// Notes: Errors go back to back or spaced by a gap.
module link_far_end (
    input wire logic clk_i,
    output logic [1:0] link_o, crc_o, st_err_o, st_rst_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {link_o, crc_o, st_err_o, st_rst_o} = 8'h00;
    task automatic errs(input int p, input int n, input int gap);
        repeat (n) begin
            @(negedge clk_i) crc_o[p] = 1'b1;
            repeat (gap) @(negedge clk_i) crc_o[p] = 1'b0;
        end
        @(negedge clk_i) crc_o[p] = 1'b0;
    endtask : errs
    task automatic selftest(input int p, input bit restart);
        @(negedge clk_i);
        if (restart) st_rst_o[p] = 1'b1;
        else st_err_o[p] = 1'b1;
        @(negedge clk_i) {st_err_o[p], st_rst_o[p]} = 2'b00;
    endtask : selftest
    task automatic set_link(input int p, input logic v);
        @(negedge clk_i) link_o[p] = v;
    endtask : set_link
endmodule : link_far_end

// ### tb/remote_slave_map_link_status_test.sv
// Purpose: Self-checking bench for the remote map and link status bank.
// Assumes: Inputs change on the falling clock edge.
// Notes: Results are queued when requested and checked when they appear.
module remote_slave_map_link_status_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, wen = 0, ren = 0, sel = 0, crst = 0, clkv = 1, rqv = 0, rqp = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [6:0] rqa = 7'h00, faddr, ra;
    logic [6:0] tgt[2], al[2];
    logic rvalid, fv, fb, fr;
    logic [1:0] link, crc, ste, str;
    logic [7:0] offs[5] = '{8'h07, 8'h08, 8'h0A, 8'h0B, 8'h20};
    logic [7:0] rq[$];
    logic [8:0] fq[$];
    int fail_count = 0, compares = 0, cycles = 0, seed = 4;
    always #25 clk = ~clk;
    remote_slave_map_link_status remote_slave_map_link_status_i (.CORE_CLK_I(clk),
        .SRST_I(srst), .REG_WR_I(wen), .REG_RD_I(ren), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .SECOND_PORT_SELECT_I(sel), .CRC_ERROR_RESET_I(crst), .LINK_DETECT_I(link),
        .CRC_ERROR_I(crc), .SELFTEST_CRC_ERROR_I(ste), .SELFTEST_RESTART_I(str),
        .INPUT_CLOCK_VALID_I(clkv), .REQ_VALID_I(rqv), .REQ_PORT_I(rqp), .REQ_ADDR_I(rqa),
        .FWD_VALID_O(fv), .FWD_BLOCKED_O(fb), .FWD_REMAPPED_O(fr), .FWD_ADDR_O(faddr));
    link_far_end link_far_end_i (.clk_i(clk), .link_o(link), .crc_o(crc), .st_err_o(ste),
        .st_rst_o(str));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk) {ren, addr} = {1'b1, a};
        rq.push_back(e);
        @(negedge clk) ren = 1'b0;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {wen, addr, wdata} = {1'b1, a, d};
        @(negedge clk) wen = 1'b0;
    endtask : wr
    task automatic req(input logic p, input logic [6:0] a, input logic [8:0] e);
        @(negedge clk) {rqv, rqp, rqa} = {1'b1, p, a};
        fq.push_back(e);
        @(negedge clk) rqv = 1'b0;
    endtask : req
    always @(negedge clk) begin
        if (rvalid === 1'b1) check({1'b0, rdata}, {1'b0, rq.pop_front()});
        if ((fv | fb) === 1'b1) check({fb, fr, fb ? 7'h00 : faddr}, fq.pop_front());
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        srst = 1'b0;
        foreach (offs[i]) rd(offs[i], 8'h00);
        rd(8'h0C, 8'h04);
        $display("test reset values done");
        for (int p = 0; p < 2; p++) begin
            sel = p[0];
            ra = 7'($random(seed)) | 7'h01;
            tgt[p] = ra;
            al[p] = ra ^ 7'h54;
            wr(8'h07, {tgt[p], 1'b1});
            wr(8'h08, {al[p], 1'b1});
        end
        for (int p = 0; p < 2; p++) begin
            sel = p[0];
            rd(8'h07, {tgt[p], 1'b0});
            rd(8'h08, {al[p], 1'b0});
            req(p[0], al[p], {2'b01, tgt[p]});
            req(p[0], al[p] ^ 7'h02, {2'b00, al[p] ^ 7'h02});
        end
        wr(8'h07, 8'h00);
        req(1'b1, al[1], 9'h100);
        req(1'b0, al[0], {2'b01, tgt[0]});
        wr(8'h07, {tgt[1], 1'b0});
        wr(8'h08, 8'h00);
        req(1'b1, 7'h00, 9'h100);
        $display("test mapping done");
        link_far_end_i.errs(0, 3, 2);
        link_far_end_i.errs(1, 2, 0);
        rd(8'h0C, 8'h06);
        rd(8'h0A, 8'h02);
        sel = 1'b0;
        rd(8'h0A, 8'h03);
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h06);
        crst = 1'b1;
        rd(8'h0A, 8'h00);
        rd(8'h0C, 8'h04);
        crst = 1'b0;
        link_far_end_i.errs(0, 65537, 0);
        rd(8'h0A, 8'hFF);
        rd(8'h0B, 8'hFF);
        crst = 1'b1;
        rd(8'h0B, 8'h00);
        crst = 1'b0;
        $display("test error count done");
        link_far_end_i.set_link(0, 1'b1);
        link_far_end_i.selftest(0, 1'b0);
        fork
            link_far_end_i.errs(0, 1, 0);
            begin
                @(negedge clk);
                rd(8'h0C, 8'h0F);
            end
        join
        link_far_end_i.selftest(0, 1'b1);
        rd(8'h0C, 8'h07);
        link_far_end_i.selftest(0, 1'b0);
        link_far_end_i.set_link(0, 1'b0);
        repeat (2) @(negedge clk);
        rd(8'h0C, 8'h14);
        clkv = 1'b0;
        rd(8'h0C, 8'h10);
        crst = 1'b1;
        rd(8'h0C, 8'h00);
        crst = 1'b0;
        repeat (3) @(negedge clk);
        $display("test link status done");
        final_report();
    end
endmodule : remote_slave_map_link_status_test
